/* core/perf_counter_event_select.sv */
`timescale 1ns/1ps
// How it works
// R1: Counter three select in bits 0-4; zero holds.
// R2: Counter four select in bits 5-9; zero holds.
// R3: Select one counts every clock cycle.
// R4: Select two counts completions, folded branches excluded.
// R5: Select three counts chosen time-base bit rises.
// R6: Select four adds zero, one or two dispatches.
// R7: Counter three: data cache, translation, level-two misses.
// R8: Counter three counts all taken branches.
// R9: Counter three counts mark toggles in user mode.
// R10: Counter three: store-conditional and floating-point completions.
// R11: Counter three: snoop castouts, level-two operation hits.
// R12: Counter three: load-miss cycles, stream, stall events.
// R13: Reserved encodings count nothing; software avoids them.
// R14: Counter four: castouts and table-search cycles.
// R15: Counter four: mispredicts, mark toggles in supervisor.
// R16: Counter four: intact store-conditional, sync completions.
// R17: Counter four: snoop retries, integer ops, branch stalls.
// R18: Four counters read-write at their register numbers.
// R19: User views mirror counters, read-only.
// R20: Overflow interrupt samples the causing instruction address.
// R21: Other interrupts sample last completed; address read-write.
// R22: User view mirrors the sampled address, read-only.
// R23: Overflow when sign bit sets; interrupt needs enables.
// R24: Freeze bit stops all counters after interrupt.
// R25: Mirrors read identically; mirror writes are ignored.
module perf_counter_event_select
   import perf_counter_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [9:0] sprNum,
   input wire logic sprWrEn,
   input wire logic [31:0] sprWrData,
   input wire logic sprRdEn,
   output logic [31:0] sprRdData,
   output logic sprRdValid,
   output logic sprRdHit,
   input wire logic [31:0] monitorControlOne,
   input wire logic [31:0] monitorControlTwo,
   input wire logic monitorIntEnable,
   input wire logic freezeOnInterrupt,
   input wire logic counterIntControl3,
   input wire logic counterIntControl4,
   input wire logic [63:0] timeBase,
   input wire logic [1:0] completedCount,
   input wire logic [1:0] dispatchedCount,
   input wire logic l1DataMiss,
   input wire logic dataTranslationBufferMiss,
   input wire logic l2DataMiss,
   input wire logic takenBranch,
   input wire logic processMarkBit,
   input wire logic userMode,
   input wire logic storeCondDone,
   input wire logic fpuDone,
   input wire logic snoopCastout,
   input wire logic l2OpHit,
   input wire logic l1LoadMissCycle,
   input wire logic spec2Resolved,
   input wire logic branchUnitDepStall,
   input wire logic l2Castout,
   input wire logic dtbSearchCycle,
   input wire logic mispredictedBranch,
   input wire logic storeCondIntact,
   input wire logic syncDone,
   input wire logic snoopRetry,
   input wire logic integerDone,
   input wire logic branchUnitTwoStall,
   input wire logic causeInstrAddrValid,
   input wire logic [31:0] causeInstrAddr,
   input wire logic [31:0] lastCompletedAddr,
   input wire logic otherMonitorInt,
   output logic monitorIntSignal,
   output logic countersFrozen
);

   logic [31:0] counterOne_r;
   logic [31:0] counterTwo_r;
   logic [31:0] counterThree_r;
   logic [31:0] counterThree_nxt;
   logic [31:0] counterFour_r;
   logic [31:0] counterFour_nxt;
   logic [31:0] sampledAddr_r;
   logic [31:0] sprRdData_r;
   logic sprRdValid_r;
   logic sprRdHit_r;
   logic monitorIntSignal_r;
   logic frozen_r;
   logic tbBit;
   logic tbBitPrev_r;
   logic tbRise;
   logic pmPrev_r;
   logic pmToggle;
   logic [4:0] selThree;
   logic [4:0] selFour;
   logic [1:0] tbSelect;
   logic [31:0] singleThree;
   logic [31:0] singleFour;
   logic [1:0] incThree;
   logic [1:0] incFour;
   logic overflowThree;
   logic overflowFour;
   logic thresholdInt;
   logic wrThree;
   logic wrFour;
   logic wrOne;
   logic wrTwo;
   logic wrAddr;
   logic anyInt;
   logic historyValid_r;

   // Amount to add this cycle for one counter; multi-count events are the
   // only ones that can add two.
   function automatic logic [1:0] incFor(
      input logic [4:0] sel,
      input logic [31:0] single,
      input logic [1:0] cmpl,
      input logic [1:0] disp
   );
      logic [1:0] amt;
      amt = 2'h0;
      case (sel)
         SEL_HOLD: amt = 2'h0;
         SEL_COMPLETED: amt = cmpl;
         SEL_DISPATCHED: amt = disp;
         default: amt = {1'b0, single[sel]};
      endcase
      return amt;
   endfunction

   // Register-number decode, used by the write strobes only.
   function automatic logic isSpr(input logic [9:0] num, input logic [9:0] ref_num);
      return num == ref_num;
   endfunction

   // The numbers that the read port answers.
   // Any other number reads back as zero with hit low.
   function automatic logic isMapped(input logic [9:0] num);
      return num inside {SPR_USER_COUNTER_VIEW_1, SPR_USER_COUNTER_VIEW_2, SPR_USER_SAMPLED_INSTR_VIEW,
         SPR_USER_COUNTER_VIEW_3, SPR_USER_COUNTER_VIEW_4, SPR_EVENT_COUNTER_1, SPR_EVENT_COUNTER_2,
         SPR_SAMPLED_INSTR_ADDRESS, SPR_EVENT_COUNTER_3, SPR_EVENT_COUNTER_4};
   endfunction

   // Both select fields sit at the top of the word, counter three first.
   assign selThree = monitorControlTwo[SEL_THREE_LSB +: SEL_WIDTH]; // [R1]
   assign selFour = monitorControlTwo[SEL_FOUR_LSB +: SEL_WIDTH]; // [R2]
   assign tbSelect = monitorControlOne[TB_SELECT_LSB +: 2];

   // All four select values are legal, so the last one is the default.
   always_comb begin
      case (tbSelect)
         2'h0: tbBit = timeBase[TB_BIT_SEL0];
         2'h1: tbBit = timeBase[TB_BIT_SEL1];
         2'h2: tbBit = timeBase[TB_BIT_SEL2];
         default: tbBit = timeBase[TB_BIT_SEL3];
      endcase
   end

   // Both edge detectors start from zero, which need not be the live level.
   // Counting waits one edge after reset, so a bit that is already high
   // is not taken for a fresh edge.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         historyValid_r <= 1'b0;
      end else begin
         historyValid_r <= 1'b1;
      end
   end

   // The time base runs on the processor clock, so its bit needs no sync.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tbBitPrev_r <= 1'b0;
      end else begin
         tbBitPrev_r <= tbBit;
      end
   end

   assign tbRise = tbBit & ~tbBitPrev_r & historyValid_r; // [R5]

   // The mark bit is a level; any change is one toggle, and the mode input
   // decides which counter may see it.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pmPrev_r <= 1'b0;
      end else begin
         pmPrev_r <= processMarkBit;
      end
   end

   assign pmToggle = (processMarkBit ^ pmPrev_r) & historyValid_r;

   // Reserved encodings keep a zero in their slot and so count nothing.
   always_comb begin
      singleThree = 32'h0000_0000; // [R13]
      singleThree[SEL_CYCLES] = 1'b1; // [R3]
      singleThree[SEL_TB_RISE] = tbRise; // [R5]
      singleThree[SEL3_L1_DMISS] = l1DataMiss; // [R7]
      singleThree[SEL3_DTB_MISS] = dataTranslationBufferMiss; // [R7]
      singleThree[SEL3_L2_DMISS] = l2DataMiss; // [R7]
      singleThree[SEL3_TAKEN_BR] = takenBranch; // [R8]
      singleThree[SEL3_PM_USER] = pmToggle & userMode; // [R9]
      singleThree[SEL3_STCX_DONE] = storeCondDone; // [R10]
      singleThree[SEL3_FPU_DONE] = fpuDone; // [R10]
      singleThree[SEL3_SNOOP_CASTOUT] = snoopCastout; // [R11]
      singleThree[SEL3_L2_OP_HIT] = l2OpHit; // [R11]
      singleThree[SEL3_L1_LOAD_MISS_CYC] = l1LoadMissCycle; // [R12]
      singleThree[SEL3_SPEC2_RESOLVED] = spec2Resolved; // [R12]
      singleThree[SEL3_BR_DEP_STALL] = branchUnitDepStall; // [R12]
   end

   // Counter four shares the slots of the common encodings.
   always_comb begin
      singleFour = 32'h0000_0000; // [R13]
      singleFour[SEL_CYCLES] = 1'b1; // [R3]
      singleFour[SEL_TB_RISE] = tbRise; // [R5]
      singleFour[SEL4_L2_CASTOUT] = l2Castout; // [R14]
      singleFour[SEL4_DTB_SEARCH_CYC] = dtbSearchCycle; // [R14]
      singleFour[SEL4_MISPREDICT] = mispredictedBranch; // [R15]
      singleFour[SEL4_PM_SUPER] = pmToggle & ~userMode; // [R15]
      singleFour[SEL4_STCX_INTACT] = storeCondIntact; // [R16]
      singleFour[SEL4_SYNC_DONE] = syncDone; // [R16]
      singleFour[SEL4_SNOOP_RETRY] = snoopRetry; // [R17]
      singleFour[SEL4_INT_DONE] = integerDone; // [R17]
      singleFour[SEL4_TWO_BR_STALL] = branchUnitTwoStall; // [R17]
   end

   // The completed count arrives with folded branches already removed.
   assign incThree = incFor(selThree, singleThree, completedCount, dispatchedCount); // [R4] [R6]
   assign incFour = incFor(selFour, singleFour, completedCount, dispatchedCount); // [R4] [R6]

   // A frozen counter keeps its value, yet software may still load it.
   assign counterThree_nxt = frozen_r ? counterThree_r : counterThree_r + {30'h0000_0000, incThree}; // [R24]
   assign counterFour_nxt = frozen_r ? counterFour_r : counterFour_r + {30'h0000_0000, incFour}; // [R24]

   // One write strobe per register; the mirror numbers get none, which
   // is what keeps them read-only.
   assign wrThree = sprWrEn & isSpr(sprNum, SPR_EVENT_COUNTER_3);
   assign wrFour = sprWrEn & isSpr(sprNum, SPR_EVENT_COUNTER_4);
   assign wrOne = sprWrEn & isSpr(sprNum, SPR_EVENT_COUNTER_1);
   assign wrTwo = sprWrEn & isSpr(sprNum, SPR_EVENT_COUNTER_2);
   assign wrAddr = sprWrEn & isSpr(sprNum, SPR_SAMPLED_INSTR_ADDRESS);

   // Overflow is the sign bit set by counting; a software load of an
   // overflowed value is not treated as an overflow event here.
   assign overflowThree = ~wrThree & ~counterThree_r[31] & counterThree_nxt[31]; // [R23]
   assign overflowFour = ~wrFour & ~counterFour_r[31] & counterFour_nxt[31]; // [R23]
   assign thresholdInt = monitorIntEnable & ((overflowThree & counterIntControl3)
      | (overflowFour & counterIntControl4)); // [R23]

   // Any cause at all; it drives the pulse, the freeze and the address sample.
   assign anyInt = thresholdInt | (monitorIntEnable & otherMonitorInt);

   // A software load in the same cycle as an increment wins over the count.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         counterThree_r <= COUNTER_RESET;
      end else if (wrThree) begin
         counterThree_r <= sprWrData; // [R18]
      end else begin
         counterThree_r <= counterThree_nxt; // [R1]
      end
   end

   // Counter four follows the same order: a load beats the count.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         counterFour_r <= COUNTER_RESET;
      end else if (wrFour) begin
         counterFour_r <= sprWrData; // [R18]
      end else begin
         counterFour_r <= counterFour_nxt; // [R2]
      end
   end

   // Counters one and two count elsewhere; here they are plain storage.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         counterOne_r <= COUNTER_RESET;
      end else if (wrOne) begin
         counterOne_r <= sprWrData; // [R18]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         counterTwo_r <= COUNTER_RESET;
      end else if (wrTwo) begin
         counterTwo_r <= sprWrData; // [R18]
      end
   end

   // The line follows its causes one cycle late; an overflow lasts one cycle.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         monitorIntSignal_r <= 1'b0;
      end else begin
         monitorIntSignal_r <= anyInt; // [R23]
      end
   end

   // The freeze holds until software drops the freeze bit; a new interrupt
   // in that same cycle does not keep it set.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         frozen_r <= 1'b0;
      end else if (freezeOnInterrupt && anyInt) begin
         frozen_r <= 1'b1; // [R24]
      end else if (!freezeOnInterrupt) begin
         frozen_r <= 1'b0;
      end
   end

   // Hardware sampling wins over a software write in the same cycle, so an
   // interrupt's address is never lost.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sampledAddr_r <= ADDRESS_RESET;
      end else if (thresholdInt && causeInstrAddrValid) begin
         sampledAddr_r <= causeInstrAddr; // [R20]
      end else if (anyInt) begin
         sampledAddr_r <= lastCompletedAddr; // [R21]
      end else if (wrAddr) begin
         sampledAddr_r <= sprWrData; // [R21]
      end
   end

   // Mirror numbers have no write path at all.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sprRdData_r <= READ_UNMAPPED;
      end else if (sprRdEn) begin
         case (sprNum)
            SPR_EVENT_COUNTER_1, SPR_USER_COUNTER_VIEW_1: sprRdData_r <= counterOne_r; // [R18] [R19]
            SPR_EVENT_COUNTER_2, SPR_USER_COUNTER_VIEW_2: sprRdData_r <= counterTwo_r; // [R18] [R19]
            SPR_EVENT_COUNTER_3, SPR_USER_COUNTER_VIEW_3: sprRdData_r <= counterThree_r; // [R19] [R25]
            SPR_EVENT_COUNTER_4, SPR_USER_COUNTER_VIEW_4: sprRdData_r <= counterFour_r; // [R19] [R25]
            SPR_SAMPLED_INSTR_ADDRESS, SPR_USER_SAMPLED_INSTR_VIEW: sprRdData_r <= sampledAddr_r; // [R22] [R25]
            default: sprRdData_r <= READ_UNMAPPED;
         endcase
      end
   end

   // Hit is kept apart from the data so that an empty read is told apart.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sprRdHit_r <= 1'b0;
      end else if (sprRdEn) begin
         sprRdHit_r <= isMapped(sprNum);
      end
   end

   // Valid follows every read strobe, mapped or not, so a read always
   // gets an answer one cycle later.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sprRdValid_r <= 1'b0;
      end else begin
         sprRdValid_r <= sprRdEn;
      end
   end

   // Every output comes straight from a flip-flop, so none has a
   // combinational path back to an input.
   assign sprRdData = sprRdData_r;
   assign sprRdValid = sprRdValid_r;
   assign sprRdHit = sprRdHit_r;
   assign monitorIntSignal = monitorIntSignal_r;
   assign countersFrozen = frozen_r;

endmodule

/* core/perf_counter_pkg.sv */
package perf_counter_pkg;

   // Register numbers as used by the special-register move instructions.
   localparam logic [9:0] SPR_USER_COUNTER_VIEW_1 = 10'h3A9;
   localparam logic [9:0] SPR_USER_COUNTER_VIEW_2 = 10'h3AA;
   localparam logic [9:0] SPR_USER_SAMPLED_INSTR_VIEW = 10'h3AB;
   localparam logic [9:0] SPR_USER_COUNTER_VIEW_3 = 10'h3AD;
   localparam logic [9:0] SPR_USER_COUNTER_VIEW_4 = 10'h3AE;
   localparam logic [9:0] SPR_EVENT_COUNTER_1 = 10'h3B9;
   localparam logic [9:0] SPR_EVENT_COUNTER_2 = 10'h3BA;
   localparam logic [9:0] SPR_SAMPLED_INSTR_ADDRESS = 10'h3BB;
   localparam logic [9:0] SPR_EVENT_COUNTER_3 = 10'h3BD;
   localparam logic [9:0] SPR_EVENT_COUNTER_4 = 10'h3BE;

   // Field positions use little-endian numbering of the 32-bit control word:
   // architectural bit n sits at index 31-n.
   localparam int SEL_THREE_LSB = 27;
   localparam int SEL_FOUR_LSB = 22;
   localparam int SEL_WIDTH = 5;
   localparam int TB_SELECT_LSB = 23;

   // Time-base bits picked by the time-base bit select, as indices of a
   // 64-bit little-endian time base (architectural bits 47, 51, 55, 63).
   localparam int TB_BIT_SEL0 = 16;
   localparam int TB_BIT_SEL1 = 12;
   localparam int TB_BIT_SEL2 = 8;
   localparam int TB_BIT_SEL3 = 0;

   localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
   localparam logic [31:0] ADDRESS_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // Encodings shared by both select fields.
   localparam logic [4:0] SEL_HOLD = 5'h00;
   localparam logic [4:0] SEL_CYCLES = 5'h01;
   localparam logic [4:0] SEL_COMPLETED = 5'h02;
   localparam logic [4:0] SEL_TB_RISE = 5'h03;
   localparam logic [4:0] SEL_DISPATCHED = 5'h04;

   // Encodings of counter three.
   localparam logic [4:0] SEL3_L1_DMISS = 5'h05;
   localparam logic [4:0] SEL3_DTB_MISS = 5'h06;
   localparam logic [4:0] SEL3_L2_DMISS = 5'h07;
   localparam logic [4:0] SEL3_TAKEN_BR = 5'h08;
   localparam logic [4:0] SEL3_PM_USER = 5'h09;
   localparam logic [4:0] SEL3_STCX_DONE = 5'h0A;
   localparam logic [4:0] SEL3_FPU_DONE = 5'h0B;
   localparam logic [4:0] SEL3_SNOOP_CASTOUT = 5'h0C;
   localparam logic [4:0] SEL3_L2_OP_HIT = 5'h0D;
   localparam logic [4:0] SEL3_L1_LOAD_MISS_CYC = 5'h0F;
   localparam logic [4:0] SEL3_SPEC2_RESOLVED = 5'h10;
   localparam logic [4:0] SEL3_BR_DEP_STALL = 5'h11;

   // Encodings of counter four.
   localparam logic [4:0] SEL4_L2_CASTOUT = 5'h05;
   localparam logic [4:0] SEL4_DTB_SEARCH_CYC = 5'h06;
   localparam logic [4:0] SEL4_MISPREDICT = 5'h08;
   localparam logic [4:0] SEL4_PM_SUPER = 5'h09;
   localparam logic [4:0] SEL4_STCX_INTACT = 5'h0A;
   localparam logic [4:0] SEL4_SYNC_DONE = 5'h0B;
   localparam logic [4:0] SEL4_SNOOP_RETRY = 5'h0C;
   localparam logic [4:0] SEL4_INT_DONE = 5'h0D;
   localparam logic [4:0] SEL4_TWO_BR_STALL = 5'h0E;

endpackage

/* test/perf_counter_event_select_props.sv */
`timescale 1ns/1ps
module perf_counter_event_select_props
   import perf_counter_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [9:0] sprNum,
   input wire logic sprRdEn,
   input wire logic [31:0] sprRdData,
   input wire logic sprRdValid,
   input wire logic sprRdHit,
   input wire logic monitorIntEnable,
   input wire logic freezeOnInterrupt,
   input wire logic otherMonitorInt,
   input wire logic monitorIntSignal,
   input wire logic countersFrozen
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic mapped;
   assign mapped = sprNum inside {SPR_USER_COUNTER_VIEW_1, SPR_USER_COUNTER_VIEW_2, SPR_USER_SAMPLED_INSTR_VIEW,
      SPR_USER_COUNTER_VIEW_3, SPR_USER_COUNTER_VIEW_4, SPR_EVENT_COUNTER_1, SPR_EVENT_COUNTER_2,
      SPR_SAMPLED_INSTR_ADDRESS, SPR_EVENT_COUNTER_3, SPR_EVENT_COUNTER_4};
   a_read_answer: assert property (sprRdEn |=> sprRdValid)
      else $error("read not answered");
   a_valid_pulse: assert property (!sprRdEn |=> !sprRdValid)
      else $error("read valid without read");
   a_unmapped_read: assert property (sprRdEn && !mapped |=> !sprRdHit && sprRdData == READ_UNMAPPED)
      else $error("unmapped read not empty");
   a_mapped_hit: assert property (sprRdEn && mapped |=> sprRdHit)
      else $error("mapped read missed");
   a_read_stands: assert property (!sprRdEn |=> $stable(sprRdData) && $stable(sprRdHit))
      else $error("read data changed without read");
   a_int_enabled: assert property (monitorIntSignal |-> $past(monitorIntEnable))
      else $error("interrupt while disabled");
   a_other_int: assert property (otherMonitorInt && monitorIntEnable |=> monitorIntSignal)
      else $error("other interrupt lost");
   a_freeze_sets: assert property (otherMonitorInt && monitorIntEnable && freezeOnInterrupt |=> countersFrozen)
      else $error("no freeze on interrupt");
   a_freeze_clear: assert property (!freezeOnInterrupt |=> !countersFrozen)
      else $error("freeze stuck");
   a_freeze_holds: assert property ($fell(countersFrozen) |-> !$past(freezeOnInterrupt))
      else $error("freeze dropped early");
endmodule
bind perf_counter_event_select perf_counter_event_select_props perf_counter_event_select_props_inst (.ref_clk,
   .rst_n, .sprNum, .sprRdEn, .sprRdData, .sprRdValid, .sprRdHit, .monitorIntEnable, .freezeOnInterrupt,
   .otherMonitorInt, .monitorIntSignal, .countersFrozen);

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import perf_counter_pkg::*;
;
   logic ref_clk, rst_n, sprWrEn, sprRdEn, monitorIntEnable, freezeOnInterrupt, counterIntControl3;
   logic counterIntControl4, processMarkBit, userMode, causeInstrAddrValid, otherMonitorInt;
   logic sprRdValid, sprRdHit, monitorIntSignal, countersFrozen, h;
   logic [9:0] sprNum;
   logic [31:0] sprWrData, monitorControlOne, monitorControlTwo, causeInstrAddr, lastCompletedAddr;
   logic [31:0] sprRdData, d, pulses;
   logic [63:0] timeBase;
   logic [63:0] tbPat [4];
   logic [1:0] completedCount, dispatchedCount;
   logic [18:0] evt;
   logic [3:0] pmPat;
   int err_total, n_compared;
   localparam logic [9:0] RW [5] = '{SPR_EVENT_COUNTER_1, SPR_EVENT_COUNTER_2, SPR_SAMPLED_INSTR_ADDRESS,
      SPR_EVENT_COUNTER_3, SPR_EVENT_COUNTER_4};
   localparam logic [9:0] VIEW [5] = '{SPR_USER_COUNTER_VIEW_1, SPR_USER_COUNTER_VIEW_2,
      SPR_USER_SAMPLED_INSTR_VIEW, SPR_USER_COUNTER_VIEW_3, SPR_USER_COUNTER_VIEW_4};
   localparam logic [4:0] C3 [11] = '{SEL3_L1_DMISS, SEL3_DTB_MISS, SEL3_L2_DMISS, SEL3_TAKEN_BR, SEL3_STCX_DONE,
      SEL3_FPU_DONE, SEL3_SNOOP_CASTOUT, SEL3_L2_OP_HIT, SEL3_L1_LOAD_MISS_CYC, SEL3_SPEC2_RESOLVED,
      SEL3_BR_DEP_STALL};
   localparam logic [4:0] C4 [8] = '{SEL4_L2_CASTOUT, SEL4_DTB_SEARCH_CYC, SEL4_MISPREDICT, SEL4_STCX_INTACT,
      SEL4_SYNC_DONE, SEL4_SNOOP_RETRY, SEL4_INT_DONE, SEL4_TWO_BR_STALL};
   localparam logic [4:0] RSV3 [4] = '{SEL_HOLD, 5'h0E, 5'h12, 5'h1F};
   localparam logic [4:0] RSV4 [4] = '{SEL_HOLD, 5'h07, 5'h0F, 5'h1F};
   localparam int TBI [4] = '{TB_BIT_SEL0, TB_BIT_SEL1, TB_BIT_SEL2, TB_BIT_SEL3};
   perf_counter_event_select perf_counter_event_select_inst (.ref_clk, .rst_n, .sprNum, .sprWrEn, .sprWrData,
      .sprRdEn, .sprRdData, .sprRdValid, .sprRdHit, .monitorControlOne, .monitorControlTwo, .monitorIntEnable,
      .freezeOnInterrupt, .counterIntControl3, .counterIntControl4, .timeBase, .completedCount, .dispatchedCount,
      .l1DataMiss(evt[0]), .dataTranslationBufferMiss(evt[1]), .l2DataMiss(evt[2]), .takenBranch(evt[3]),
      .processMarkBit, .userMode, .storeCondDone(evt[4]), .fpuDone(evt[5]), .snoopCastout(evt[6]),
      .l2OpHit(evt[7]), .l1LoadMissCycle(evt[8]), .spec2Resolved(evt[9]), .branchUnitDepStall(evt[10]),
      .l2Castout(evt[11]), .dtbSearchCycle(evt[12]), .mispredictedBranch(evt[13]), .storeCondIntact(evt[14]),
      .syncDone(evt[15]), .snoopRetry(evt[16]), .integerDone(evt[17]), .branchUnitTwoStall(evt[18]),
      .causeInstrAddrValid, .causeInstrAddr, .lastCompletedAddr, .otherMonitorInt, .monitorIntSignal,
      .countersFrozen);
   always #4 ref_clk = ~ref_clk;
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [9:0] num, input logic [31:0] data);
      sprNum = num;
      sprWrData = data;
      sprWrEn = 1'b1;
      tick();
      sprWrEn = 1'b0;
      tick();
   endtask
   // Each access ends with an idle edge, so a strobe never falls and rises in one step.
   task automatic rd(input logic [9:0] num);
      sprNum = num;
      sprRdEn = 1'b1;
      tick();
      sprRdEn = 1'b0;
      cmp({31'h0, sprRdValid}, 32'h1);
      d = sprRdData;
      h = sprRdHit;
      tick();
   endtask
   // Counts stand four edges, time base and mark bit follow their patterns, single events only on the first and third; select then holds.
   task automatic cnt(input logic four, input logic [4:0] s, input logic [18:0] e, input logic [1:0] cc,
      input logic [1:0] dd, input logic [31:0] exp);
      wr(four ? SPR_EVENT_COUNTER_4 : SPR_EVENT_COUNTER_3, 32'h0000_0100);
      monitorControlTwo = 32'(s) << (four ? SEL_FOUR_LSB : SEL_THREE_LSB);
      for (int i = 0; i < 4; i++) begin
         evt = i[0] ? 19'h0 : e;
         completedCount = cc;
         dispatchedCount = dd;
         timeBase = tbPat[i];
         processMarkBit = pmPat[i];
         tick();
      end
      monitorControlTwo = 32'h0000_0000;
      evt = 19'h0;
      completedCount = 2'h0;
      dispatchedCount = 2'h0;
      timeBase = 64'h0;
      processMarkBit = 1'b0;
      rd(four ? SPR_EVENT_COUNTER_4 : SPR_EVENT_COUNTER_3);
      cmp(d, 32'h0000_0100 + exp);
      rd(four ? SPR_USER_COUNTER_VIEW_4 : SPR_USER_COUNTER_VIEW_3);
      cmp(d, 32'h0000_0100 + exp);
   endtask
   initial begin
      #20000;
      err_total++;
      end_of_test();
   end
   initial begin
      {ref_clk, rst_n, sprWrEn, sprRdEn, monitorIntEnable, freezeOnInterrupt, counterIntControl3} = 7'h0;
      {counterIntControl4, processMarkBit, userMode, causeInstrAddrValid, otherMonitorInt} = 5'h0;
      {sprNum, sprWrData, monitorControlOne, monitorControlTwo, causeInstrAddr, lastCompletedAddr} = '0;
      {timeBase, completedCount, dispatchedCount, evt, pmPat} = '0;
      tbPat = '{64'h0, 64'h0, 64'h0, 64'h0};
      err_total = 0;
      n_compared = 0;
      repeat (6) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      tick();
      for (int i = 0; i < 5; i++) begin
         rd(RW[i]);
         cmp(d, COUNTER_RESET);
         wr(RW[i], 32'h1357_0000 + 32'(i));
         wr(VIEW[i], 32'hFFFF_FFFF);
         rd(RW[i]);
         cmp(d, 32'h1357_0000 + 32'(i));
         rd(VIEW[i]);
         cmp(d, 32'h1357_0000 + 32'(i));
      end
      rd(10'h3AC);
      cmp({h, d[30:0]}, 32'h0);
      for (int k = 0; k < 2; k++) begin
         cnt(k[0], SEL_CYCLES, 19'h0, 2'h0, 2'h0, 32'h4);
         cnt(k[0], SEL_COMPLETED, 19'h0, 2'h1, 2'h2, 32'h4);
         cnt(k[0], SEL_DISPATCHED, 19'h0, 2'h1, 2'h2, 32'h8);
         for (int t = 0; t < 4; t++) begin
            monitorControlOne = 32'(t) << TB_SELECT_LSB;
            tbPat = '{64'h1 << TBI[t], 64'h0, ~(64'h1 << TBI[t]), 64'h1 << TBI[t]};
            cnt(k[0], SEL_TB_RISE, 19'h0, 2'h0, 2'h0, 32'h2);
         end
      end
      for (int i = 0; i < 11; i++) cnt(1'b0, C3[i], 19'h1 << i, 2'h0, 2'h0, 32'h2);
      for (int i = 0; i < 8; i++) cnt(1'b1, C4[i], 19'h1 << (i + 11), 2'h0, 2'h0, 32'h2);
      tbPat = '{64'h0, '1, 64'h0, '1};
      pmPat = 4'b0101;
      userMode = 1'b1;
      cnt(1'b0, SEL3_PM_USER, 19'h0, 2'h0, 2'h0, 32'h4);
      cnt(1'b1, SEL4_PM_SUPER, 19'h0, 2'h0, 2'h0, 32'h0);
      userMode = 1'b0;
      cnt(1'b0, SEL3_PM_USER, 19'h0, 2'h0, 2'h0, 32'h0);
      cnt(1'b1, SEL4_PM_SUPER, 19'h0, 2'h0, 2'h0, 32'h4);
      for (int j = 0; j < 4; j++) begin
         cnt(1'b0, RSV3[j], '1, 2'h2, 2'h2, 32'h0);
         cnt(1'b1, RSV4[j], '1, 2'h2, 2'h2, 32'h0);
      end
      wr(SPR_EVENT_COUNTER_3, 32'h7FFF_FFFE);
      wr(SPR_EVENT_COUNTER_4, 32'h0000_0000);
      {counterIntControl3, counterIntControl4, monitorIntEnable, freezeOnInterrupt, causeInstrAddrValid} = 5'h1F;
      causeInstrAddr = 32'h0000_4A40;
      lastCompletedAddr = 32'h0000_5B50;
      monitorControlTwo = (32'(SEL_CYCLES) << SEL_THREE_LSB) | (32'(SEL_CYCLES) << SEL_FOUR_LSB);
      pulses = 32'h0;
      for (int i = 0; i < 6; i++) begin
         tick();
         pulses = pulses + {31'h0, monitorIntSignal};
      end
      cmp(pulses, 32'h1);
      rd(SPR_EVENT_COUNTER_3);
      cmp(d, 32'h8000_0000);
      rd(SPR_EVENT_COUNTER_4);
      cmp(d, 32'h0000_0002);
      rd(SPR_USER_SAMPLED_INSTR_VIEW);
      cmp(d, 32'h0000_4A40);
      {counterIntControl3, freezeOnInterrupt, causeInstrAddrValid} = 3'h0;
      monitorControlTwo = 32'h0;
      tick();
      cmp({31'h0, countersFrozen}, 32'h0);
      freezeOnInterrupt = 1'b1;
      otherMonitorInt = 1'b1;
      tick();
      otherMonitorInt = 1'b0;
      cmp({30'h0, monitorIntSignal, countersFrozen}, 32'h3);
      freezeOnInterrupt = 1'b0;
      rd(SPR_SAMPLED_INSTR_ADDRESS);
      cmp(d, 32'h0000_5B50);
      monitorIntEnable = 1'b0;
      otherMonitorInt = 1'b1;
      tick();
      otherMonitorInt = 1'b0;
      cmp({31'h0, monitorIntSignal}, 32'h0);
      end_of_test();
   end
endmodule
